// ==== rtl/bus_ctl_map.svh ====
// Offsets, field positions and reset values of the bus control block.
// Included by the package users; definitions only.
`ifndef BUS_CTL_MAP_SVH
`define BUS_CTL_MAP_SVH

// Register port byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_PC 8'h08
`define OFS_SP 8'h0C
`define OFS_RDATA 8'h10

// Control register fields (write pulses)
`define CTRL_IE_SET 0
`define CTRL_IE_CLR 1

// Status register fields
`define STS_GRANT 0
`define STS_IE 1
`define STS_IRQ_ACC 2
`define STS_HALTED 3
`define STS_STALL 4
`define STS_STATE_LO 8

// Reset values
`define PC_RESET 16'h0000
`define ADDR_RESET 16'h0000
`define DATA_RESET 8'h00

`endif

// ==== rtl/bus_ctl_pkg.sv ====
// Types shared by the bus control block and its users.
// Assumes the core side issues one machine-cycle request at a time.
package bus_ctl_pkg;

	typedef enum logic [1:0] {SEL_REQ, SEL_PC, SEL_PUSH, SEL_POP} addr_sel_e;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ONE, ST_TWO, ST_STALL, ST_THREE, ST_HOLD, ST_HALT
	} cyc_state_e;

	typedef struct packed {
		logic [7:0] status;
		logic [15:0] addr;
		logic [7:0] wdata;
		addr_sel_e sel;
		logic is_io;
		logic is_write;
		logic is_last;
		logic is_halt;
		logic set_ie;
		logic clr_ie;
	} cycle_req_s;

endpackage

// ==== rtl/bus_ctl.sv ====
// Machine-cycle sequencer driving the processor address, data and control pins.
// Assumes all pin inputs are synchronous to clk; one clk period per clock state.
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "bus_ctl_map.svh"

// Functional notes
// - Drive 16-bit address; I/O port number selects one of 256 ports.
// - Status byte is on the data bus in state one.
// - Cycle-start strobe marks the first state of each machine cycle.
// - Input-phase indicator high while the data bus expects external data.
// - Ready low after address issue inserts stall states until it rises.
// - Stall output is high for each stall state.
// - Holding ready low lets external logic step one machine cycle.
// - Write strobe low only while write data is already stable.
// - Release request seen only when halted, or in state two/stall with ready.
// - In bus release both address and data buses float.
// - Grant rises at state three for reads, one state later for writes.
// - Interrupt enable output shows the enable flip-flop; clear flag refuses.
// - Enable flag clears in state one of an accepted interrupt fetch, and on reset.
// - Interrupt request sampled at instruction end or while halted.
// - No interrupt taken during bus release or with the flag clear.
// - Reset clears program counter, enable flag and grant.
// - Reset leaves the stack pointer untouched.
// - Stack lives in external memory, addressed by a 16-bit stack pointer.
// - Interrupt sampled in the last state of an instruction, acted on next.
module bus_ctl (
	input wire logic clk,
	input wire logic sys_rst,
	// Core side
	input wire bus_ctl_pkg::cycle_req_s cyc_req,
	input wire logic cyc_valid,
	output logic cyc_ready,
	output logic [7:0] cyc_rdata,
	output logic cyc_rdata_valid,
	output logic irq_accept,
	output logic irq_taken,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [31:0] reg_rdata,
	// Pins
	output logic [15:0] address_lines,
	output logic address_lines_oe,
	input wire logic [7:0] data_lines_in,
	output logic [7:0] data_lines_out,
	output logic data_lines_oe,
	output logic cycle_start,
	output logic bus_input_phase,
	output logic write_n,
	input wire logic ready,
	output logic stall_ack,
	input wire logic hold_req,
	output logic bus_release_grant,
	input wire logic irq_req,
	output logic irq_enable_flag
);

	bus_ctl_pkg::cyc_state_e state;
	bus_ctl_pkg::cyc_state_e next_state;
	bus_ctl_pkg::cycle_req_s cur;
	logic [15:0] pc;
	logic [15:0] sp;
	logic [7:0] last_rdata;
	logic hold_seen;
	logic halt_ret;
	logic start_cycle;
	logic hold_ok;
	logic irq_ok;
	logic end_cycle;
	logic fetch_start;
	logic ack_fetch;
	logic ctrl_wr;
	logic grant_drop;

	// Request accepted only when idle; one machine cycle in flight
	assign cyc_ready = (state == bus_ctl_pkg::ST_IDLE);
	assign start_cycle = cyc_ready && cyc_valid;
	assign end_cycle = (state == bus_ctl_pkg::ST_THREE);
	assign fetch_start = start_cycle && (cyc_req.sel == bus_ctl_pkg::SEL_PC);
	// A fetch started with an interrupt pending is its acknowledge
	assign ack_fetch = fetch_start && irq_accept;
	assign ctrl_wr = reg_we && (reg_addr == `OFS_CTRL);

	// Withdrawal drops the grant in any state
	// Dropping it only in release would leave it up through state three of a read
	assign grant_drop = bus_release_grant && !hold_req;

	assign hold_ok = hold_req && (((state == bus_ctl_pkg::ST_TWO ||
		state == bus_ctl_pkg::ST_STALL) && ready) || state == bus_ctl_pkg::ST_HALT);

	// Refused in release or with flag clear
	assign irq_ok = irq_req && irq_enable_flag && !bus_release_grant;

	always_comb begin
		next_state = state;
		unique case (state)
			bus_ctl_pkg::ST_IDLE: begin
				if (start_cycle) begin
					next_state = bus_ctl_pkg::ST_ONE;
				end
			end
			bus_ctl_pkg::ST_ONE: begin
				next_state = bus_ctl_pkg::ST_TWO;
			end
			// Ready taken as already synchronous to clk
			bus_ctl_pkg::ST_TWO, bus_ctl_pkg::ST_STALL: begin
				next_state = ready ? bus_ctl_pkg::ST_THREE : bus_ctl_pkg::ST_STALL;
			end
			bus_ctl_pkg::ST_THREE: begin
				// A request withdrawn before the cycle ends skips the release
				if (hold_seen && hold_req) begin
					next_state = bus_ctl_pkg::ST_HOLD;
				end else if (cur.is_halt) begin
					next_state = bus_ctl_pkg::ST_HALT;
				end else begin
					next_state = bus_ctl_pkg::ST_IDLE;
				end
			end
			bus_ctl_pkg::ST_HOLD: begin
				if (!hold_req) begin
					next_state = halt_ret ? bus_ctl_pkg::ST_HALT : bus_ctl_pkg::ST_IDLE;
				end
			end
			// Halt left on interrupt
			// Release outranks an interrupt while halted
			bus_ctl_pkg::ST_HALT: begin
				if (hold_ok) begin
					next_state = bus_ctl_pkg::ST_HOLD;
				end else if (irq_ok) begin
					next_state = bus_ctl_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = bus_ctl_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= bus_ctl_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cur <= '0;
		end else if (start_cycle) begin
			cur <= cyc_req;
		end
	end

	// Release request latched in its window, kept until the idle or release state
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hold_seen <= 1'b0;
		end else if (state == bus_ctl_pkg::ST_IDLE || state == bus_ctl_pkg::ST_HOLD) begin
			hold_seen <= 1'b0;
		end else if (hold_ok && state != bus_ctl_pkg::ST_HALT) begin
			hold_seen <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			halt_ret <= 1'b0;
		end else if (state == bus_ctl_pkg::ST_HALT && hold_ok) begin
			halt_ret <= 1'b1;
		end else if (end_cycle && hold_seen) begin
			halt_ret <= cur.is_halt;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_release_grant <= 1'b0;
		end else if (grant_drop) begin
			bus_release_grant <= 1'b0;
		end else if (hold_ok && ready && state != bus_ctl_pkg::ST_HALT && !cur.is_write) begin
			bus_release_grant <= 1'b1;
		end else if (end_cycle && hold_seen && hold_req && cur.is_write) begin
			bus_release_grant <= 1'b1;
		end else if (state == bus_ctl_pkg::ST_HALT && hold_ok) begin
			bus_release_grant <= 1'b1;
		end
	end

	// Address and I/O port number
	// I/O cycles repeat the port number on both address halves
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			address_lines <= `ADDR_RESET;
		end else if (start_cycle) begin
			unique case (cyc_req.sel)
				bus_ctl_pkg::SEL_REQ: begin
					address_lines <= cyc_req.is_io ? {cyc_req.addr[7:0], cyc_req.addr[7:0]}
						: cyc_req.addr;
				end
				bus_ctl_pkg::SEL_PC: begin
					address_lines <= pc;
				end
				bus_ctl_pkg::SEL_PUSH: begin
					address_lines <= sp - 16'h0001;
				end
				bus_ctl_pkg::SEL_POP: begin
					address_lines <= sp;
				end
			endcase
		end
	end

	// Program counter steps on fetch, except in an interrupt acknowledge fetch
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pc <= `PC_RESET;
		end else if (reg_we && reg_addr == `OFS_PC) begin
			pc <= reg_wdata[15:0];
		end else if (fetch_start && !irq_accept) begin
			pc <= pc + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (reg_we && reg_addr == `OFS_SP) begin
			sp <= reg_wdata[15:0];
		end else if (start_cycle && cyc_req.sel == bus_ctl_pkg::SEL_PUSH) begin
			sp <= sp - 16'h0001;
		end else if (start_cycle && cyc_req.sel == bus_ctl_pkg::SEL_POP) begin
			sp <= sp + 16'h0001;
		end
	end

	// Status in state one, then write data
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			data_lines_out <= `DATA_RESET;
		end else if (start_cycle) begin
			data_lines_out <= cyc_req.status;
		end else if (state == bus_ctl_pkg::ST_ONE) begin
			data_lines_out <= cur.wdata;
		end
	end

	assign address_lines_oe = (state != bus_ctl_pkg::ST_HOLD);
	assign data_lines_oe = (state == bus_ctl_pkg::ST_ONE) || (cur.is_write &&
		(state == bus_ctl_pkg::ST_TWO || state == bus_ctl_pkg::ST_STALL ||
		state == bus_ctl_pkg::ST_THREE));

	assign cycle_start = (state == bus_ctl_pkg::ST_ONE);

	assign bus_input_phase = !cur.is_write && (state == bus_ctl_pkg::ST_TWO ||
		state == bus_ctl_pkg::ST_STALL || state == bus_ctl_pkg::ST_THREE);

	// Strobe after data settled a state earlier
	assign write_n = !(cur.is_write && (state == bus_ctl_pkg::ST_STALL ||
		state == bus_ctl_pkg::ST_THREE));

	// Ready low parks the cycle here for stepping
	assign stall_ack = (state == bus_ctl_pkg::ST_STALL);

	// Read data taken at the end of state three
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			last_rdata <= `DATA_RESET;
		end else if (end_cycle && !cur.is_write) begin
			last_rdata <= data_lines_in;
		end
	end

	assign cyc_rdata = last_rdata;

	// Valid pulses once per cycle; the byte stays readable on the register port
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cyc_rdata_valid <= 1'b0;
		end else begin
			cyc_rdata_valid <= end_cycle;
		end
	end

	// Sampled in last state, honoured on the next fetch
	// A cycle that ends in release leaves the interrupt for a later end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_accept <= 1'b0;
		end else if (fetch_start) begin
			irq_accept <= 1'b0;
		end else if (end_cycle && cur.is_last && !hold_seen && irq_ok) begin
			irq_accept <= 1'b1;
		end else if (state == bus_ctl_pkg::ST_HALT && !hold_ok && irq_ok) begin
			irq_accept <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_taken <= 1'b0;
		end else begin
			irq_taken <= ack_fetch;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_enable_flag <= 1'b0;
		end else if (ack_fetch) begin
			// Cleared when the acknowledge fetch starts
			irq_enable_flag <= 1'b0;
		// Clear wins over set when both bits are written
		end else if (ctrl_wr && reg_wdata[`CTRL_IE_CLR]) begin
			irq_enable_flag <= 1'b0;
		end else if (ctrl_wr && reg_wdata[`CTRL_IE_SET]) begin
			irq_enable_flag <= 1'b1;
		end else if (end_cycle && cur.is_last && cur.clr_ie) begin
			irq_enable_flag <= 1'b0;
		end else if (end_cycle && cur.is_last && cur.set_ie) begin
			irq_enable_flag <= 1'b1;
		end
	end

	// Register reads: data one cycle after the strobe, zero elsewhere
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_re) begin
			unique case (reg_addr)
				`OFS_STATUS: begin
					reg_rdata <= {21'h000000, 3'(state), 3'h0, stall_ack,
						(state == bus_ctl_pkg::ST_HALT), irq_accept, irq_enable_flag,
						bus_release_grant};
				end
				`OFS_PC: begin
					reg_rdata <= {16'h0000, pc};
				end
				`OFS_SP: begin
					reg_rdata <= {16'h0000, sp};
				end
				`OFS_RDATA: begin
					reg_rdata <= {24'h000000, last_rdata};
				end
				default: begin
					reg_rdata <= 32'h00000000;
				end
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

endmodule // bus_ctl

// ==== dv/bus_ctl_monitor.sv ====
// Checker for the bus control pins of bus_ctl.
// Sees only the top module ports; one clock domain.
`timescale 1ns/1ps
module bus_ctl_monitor (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cycle_start,
	input wire logic data_lines_oe,
	input wire logic address_lines_oe,
	input wire logic [7:0] data_lines_out,
	input wire logic ready,
	input wire logic stall_ack,
	input wire logic bus_input_phase,
	input wire logic write_n,
	input wire logic hold_req,
	input wire logic bus_release_grant,
	input wire logic irq_accept,
	input wire logic irq_taken,
	input wire logic irq_enable_flag
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// State one followed by a slow device
	sequence s_wait_entry;
		cycle_start ##1 !ready;
	endsequence

	a_status_drive: assert property (cycle_start |-> data_lines_oe && address_lines_oe)
		else $error("status byte not driven");
	a_stall_enter: assert property (s_wait_entry |=> stall_ack)
		else $error("no stall after ready low");
	a_stall_stay: assert property (stall_ack && !ready |=> stall_ack)
		else $error("stall left while ready low");
	a_input_phase: assert property (bus_input_phase |-> !data_lines_oe && write_n)
		else $error("data driven in input phase");
	a_write_stable: assert property (!write_n && !$past(write_n) |-> $stable(data_lines_out))
		else $error("write data moved");
	a_float_held: assert property (!address_lines_oe |-> !data_lines_oe && bus_release_grant)
		else $error("buses float without grant");
	a_grant_cause: assert property ($rose(bus_release_grant) |-> $past(hold_req))
		else $error("grant without request");
	a_grant_drop: assert property (bus_release_grant && !hold_req |=> !bus_release_grant)
		else $error("grant kept after withdrawal");
	a_irq_gate: assert property ($rose(irq_accept) |-> $past(irq_enable_flag))
		else $error("interrupt taken with flag clear");
	a_ack_clears_flag: assert property (irq_taken |-> !irq_enable_flag)
		else $error("enable flag kept through interrupt acknowledge");
endmodule // bus_ctl_monitor

bind bus_ctl bus_ctl_monitor mon (.clk, .sys_rst, .cycle_start, .data_lines_oe, .address_lines_oe,
	.data_lines_out, .ready, .stall_ack, .bus_input_phase, .write_n, .hold_req,
	.bus_release_grant, .irq_accept, .irq_taken, .irq_enable_flag);

// ==== dv/bus_mem_model.sv ====
// Memory stand-in on the far side of the pins.
// Assumes one clk per clock state; the bench sets the stall count.
`timescale 1ns/1ps
module bus_mem_model (
	input wire logic clk,
	input wire logic [15:0] address_lines,
	input wire logic [7:0] data_lines_out,
	input wire logic cycle_start,
	input wire logic bus_input_phase,
	input wire logic write_n,
	input wire logic [3:0] stall_cnt,
	output logic [7:0] data_lines_in,
	output logic ready,
	output logic [7:0] last_wr
);
	logic [3:0] cnt = 4'h0;
	logic [7:0] prev = 8'h00;
	assign ready = (cnt == 4'h0);
	always_ff @(posedge clk) begin
		if (cycle_start) cnt <= stall_cnt;
		else if (cnt != 4'h0) cnt <= cnt - 4'h1;
	end
	// drive in input phase
	// Released bus toggles so stale data never matches
	assign data_lines_in = bus_input_phase ? (address_lines[7:0] ^ 8'h5A) : ~prev;
	always_ff @(posedge clk) begin
		prev <= data_lines_in;
		if (!write_n) last_wr <= data_lines_out;
	end
endmodule // bus_mem_model

// ==== dv/bus_ctl_test.sv ====
// Self-checking bench for bus_ctl with a memory model.
// Assumes one clk per clock state and the hand-over timing.
`timescale 1ns/1ps
`include "bus_ctl_map.svh"
module bus_ctl_test;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	bus_ctl_pkg::cycle_req_s cyc_req = '0;
	logic cyc_valid = 1'b0, reg_we = 1'b0, reg_re = 1'b0, hold_req = 1'b0, irq_req = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, r;
	logic [3:0] stall_cnt = 4'h0;
	logic [15:0] address_lines;
	logic [7:0] cyc_rdata, data_lines_in, data_lines_out, last_wr;
	logic cyc_ready, cyc_rdata_valid, irq_accept, irq_taken, address_lines_oe, data_lines_oe;
	logic cycle_start, bus_input_phase, write_n, ready, stall_ack;
	logic bus_release_grant, irq_enable_flag;
	int seed = 25, err_count = 0, tests_run = 0, cyc_n = 0;

	bus_ctl dut (.clk, .sys_rst, .cyc_req, .cyc_valid, .cyc_ready, .cyc_rdata, .cyc_rdata_valid,
		.irq_accept, .irq_taken, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
		.address_lines, .address_lines_oe, .data_lines_in, .data_lines_out, .data_lines_oe,
		.cycle_start, .bus_input_phase, .write_n, .ready, .stall_ack, .hold_req,
		.bus_release_grant, .irq_req, .irq_enable_flag);
	bus_mem_model mem (.clk, .address_lines, .data_lines_out, .cycle_start, .bus_input_phase,
		.write_n, .stall_cnt, .data_lines_in, .ready, .last_wr);

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		#1 chk("reg_rdata", e, reg_rdata);
	endtask

	// Write lands one edge after the strobe
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
		@(posedge clk);
	endtask

	task automatic run_cyc(input logic [15:0] a, input logic wr, input logic [3:0] st,
		input logic last, input logic lat);
		int n;
		logic [7:0] s;
		n = 0;
		s = 8'($random(seed));
		@(posedge clk);
		cyc_req.addr <= a;
		cyc_req.is_write <= wr;
		cyc_req.is_last <= last;
		cyc_req.wdata <= a[15:8];
		cyc_req.status <= s;
		stall_cnt <= st;
		cyc_valid <= 1'b1;
		@(posedge clk);
		cyc_valid <= 1'b0;
		#1 chk("address", 32'(a), 32'(address_lines));
		chk("status", 32'(s), 32'(data_lines_out));
		while (cyc_rdata_valid !== 1'b1 && n < 60) begin
			@(posedge clk);
			#1 n++;
		end
		if (lat) chk("latency", 32'(st) + 32'd3, n);
		if (wr) chk("write data", 32'(a[15:8]), 32'(last_wr));
		else chk("read data", 32'(a[7:0] ^ 8'h5A), 32'(cyc_rdata));
	endtask

	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 6000) begin
			err_count++;
			end_sim();
		end
	end

	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		reg_rd(`OFS_PC, 32'h0);
		reg_rd(`OFS_STATUS, 32'h0);
		reg_rd(8'h20, 32'h0);
		$display("test reset done");
		run_cyc(16'hFFFF, 1'b0, 4'h0, 1'b0, 1'b1);
		run_cyc(16'h0000, 1'b1, 4'h7, 1'b0, 1'b1);
		repeat (24) begin
			r = $random(seed);
			run_cyc(r[15:0], r[16], {1'b0, r[19:17]}, 1'b0, 1'b1);
		end
		$display("test cycles done");
		for (int w = 0; w < 2; w++) begin
			@(posedge clk);
			hold_req <= 1'b1;
			fork
				run_cyc(16'h1234, w[0], 4'h0, 1'b0, 1'b0);
				begin
					wait (bus_release_grant === 1'b1);
					repeat (2) @(posedge clk);
					hold_req <= 1'b0;
					#1 chk("address oe", 0, 32'(address_lines_oe));
				end
			join
			@(posedge clk);
			#1 chk("grant", 0, 32'(bus_release_grant));
		end
		$display("test release done");
		@(posedge clk);
		irq_req <= 1'b1;
		run_cyc(16'h0042, 1'b0, 4'h1, 1'b1, 1'b1);
		chk("refused", 0, 32'(irq_accept));
		reg_wr(`OFS_CTRL, 32'h1);
		#1 chk("ie set", 1, 32'(irq_enable_flag));
		run_cyc(16'h0043, 1'b0, 4'h0, 1'b1, 1'b1);
		repeat (2) @(posedge clk);
		#1 chk("accept", 1, 32'(irq_accept));
		reg_wr(`OFS_PC, 32'h00001234);
		@(posedge clk);
		cyc_req.sel <= bus_ctl_pkg::SEL_PC;
		fork
			run_cyc(16'h1234, 1'b0, 4'h0, 1'b0, 1'b1);
			begin
				repeat (2) @(posedge clk);
				#1 chk("irq taken", 1, 32'(irq_taken));
				chk("ie ack", 0, 32'(irq_enable_flag));
			end
		join
		reg_rd(`OFS_PC, 32'h00001234);
		run_cyc(16'h1234, 1'b0, 4'h0, 1'b0, 1'b1);
		reg_rd(`OFS_PC, 32'h00001235);
		reg_wr(`OFS_CTRL, 32'h1);
		#1 chk("ie set again", 1, 32'(irq_enable_flag));
		reg_wr(`OFS_CTRL, 32'h2);
		#1 chk("ie clear", 0, 32'(irq_enable_flag));
		$display("test interrupt done");
		reg_wr(`OFS_SP, 32'h00002000);
		@(posedge clk);
		cyc_req.sel <= bus_ctl_pkg::SEL_PUSH;
		run_cyc(16'h1FFF, 1'b1, 4'h2, 1'b0, 1'b1);
		@(posedge clk);
		cyc_req.sel <= bus_ctl_pkg::SEL_POP;
		run_cyc(16'h1FFF, 1'b0, 4'h0, 1'b0, 1'b1);
		reg_rd(`OFS_SP, 32'h00002000);
		@(posedge clk);
		cyc_req.sel <= bus_ctl_pkg::SEL_REQ;
		sys_rst <= 1'b1;
		// reset held three cycles in mid run
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		reg_rd(`OFS_SP, 32'h00002000);
		reg_rd(`OFS_PC, 32'h0);
		reg_rd(`OFS_STATUS, 32'h0);
		$display("test stack and reset done");
		end_sim();
	end
endmodule // bus_ctl_test
